// [pkg/cfg_loader_defines.vh]
// constants for the transceiver configuration loader
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH
`define LEN_LONG 6'd37
`define LEN_CLKREC 6'd27
`define LEN_AUX 6'd7
`define LEN_SHORT 6'd6
`define LEN_STATUS 6'd5
`define AUX_TX 7'h45
`define AUX_RX 7'h44
`define MAIN_TX 37'h09DB005260
`define MAIN_RX 37'h0990000260
`define MAIN_RXCLK 37'h09B0000260
`define CMD_STANDBY 6'h12
`define CMD_WAKE 6'h13
`define CMD_RESET 6'h2E
`define STATUS_ADDR 5'h0B
`define TXF0_TAG 2'h0
`define TXF1_TAG 2'h1
`define RXF_TAG 2'h2
`define CLKREC_TOP 4'h7
`define RATE_DIV_RST 16'd20000
`endif

// [hdl/bit_clock_gen.v]
// recovered bit clock generator, rising edge mid-bit
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module bit_clock_gen #(
    parameter DIV_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // control
    input wire run,
    input wire [DIV_W-1:0] half_bit,
    input wire rx_data,
    // output
    output reg bit_clk
);
    reg [DIV_W-1:0] cnt_q;
    reg data_q;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {DIV_W{1'b0}};
            data_q <= 1'b0;
            bit_clk <= 1'b0;
        end else if (ce) begin
            data_q <= rx_data;
            if (!run) begin
                cnt_q <= {DIV_W{1'b0}};
                bit_clk <= 1'b0;
            end else if (data_q != rx_data) begin
                cnt_q <= {DIV_W{1'b0}};
                bit_clk <= 1'b0;
            end else if (cnt_q >= half_bit) begin
                cnt_q <= {DIV_W{1'b0}};
                bit_clk <= ~bit_clk;
            end else begin
                cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// [hdl/radio_transceiver_config_loader.v]
// serial configuration loader of the radio transceiver
// Behaviour
// - words arrive msb first, each bit captured on serial clock rising edge
// - recovered-clock receive outputs a clock rising mid data bit
// - aux already holds 45h after transmit so standby may skip it
// - after reset all registers cleared, standby, full sequence needed
// - status read is address 0101 plus read bit, six strength bits returned
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module radio_transceiver_config_loader (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // three-wire programming bus
    input wire load_enable_line,
    input wire serial_clock_line,
    input wire serial_data_line_in,
    output reg serial_data_line_out,
    output reg serial_data_line_oe_n,
    // radio side
    input wire rx_data,
    input wire [5:0] signal_strength,
    // status
    output reg tx_active,
    output reg rx_active,
    output reg standby,
    output reg recovered_clock_en,
    output wire recovered_bit_clock,
    output reg [36:0] first_tx_frequency_word,
    output reg [36:0] second_tx_frequency_word,
    output reg [36:0] rx_frequency_word,
    output reg [26:0] bit_clock_recovery_word,
    output reg [6:0] auxiliary_control_word,
    output reg [36:0] main_control_word,
    output reg word_error
);
    localparam ST_STANDBY = 3'b001;
    localparam ST_TX = 3'b010;
    localparam ST_RX = 3'b100;
    reg [1:0] le_s_q, sck_s_q, sd_s_q;
    reg le_d_q, sck_d_q;
    reg [36:0] shift_q;
    reg [5:0] count_q;
    reg [2:0] state_q, prev_q;
    reg reading_q;
    reg [2:0] rd_idx_q;
    reg [1:0] freq_seen_q;
    wire le = le_s_q[1];
    wire sck_rise = sck_s_q[1] & ~sck_d_q;
    wire sck_fall = ~sck_s_q[1] & sck_d_q;
    wire le_rise = le & ~le_d_q;
    wire le_fall = ~le & le_d_q;
    ////////////////////////////////////////////////////////////////////////////
    function is_len;
        input [5:0] cnt;
        input [5:0] len;
        begin
            is_len = (cnt == len);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge history
    always @(posedge clk) begin
        if (!rst_n) begin
            le_s_q <= 2'h3;
            sck_s_q <= 2'h0;
            sd_s_q <= 2'h0;
            le_d_q <= 1'b1;
            sck_d_q <= 1'b0;
        end else if (ce) begin
            le_s_q <= {le_s_q[0], load_enable_line};
            sck_s_q <= {sck_s_q[0], serial_clock_line};
            sd_s_q <= {sd_s_q[0], serial_data_line_in};
            le_d_q <= le_s_q[1];
            sck_d_q <= sck_s_q[1];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // shifter, word decode and mode state
    always @(posedge clk) begin
        if (!rst_n) begin
            shift_q <= 37'h0;
            count_q <= 6'h0;
            state_q <= ST_STANDBY;
            prev_q <= ST_STANDBY;
            first_tx_frequency_word <= 37'h0;
            second_tx_frequency_word <= 37'h0;
            rx_frequency_word <= 37'h0;
            bit_clock_recovery_word <= 27'h0;
            auxiliary_control_word <= 7'h0;
            main_control_word <= 37'h0;
            word_error <= 1'b0;
            reading_q <= 1'b0;
            rd_idx_q <= 3'h0;
            freq_seen_q <= 2'h0;
            serial_data_line_out <= 1'b0;
            serial_data_line_oe_n <= 1'b1;
        end else if (ce) begin
            if (le_fall) begin
                count_q <= 6'h0;
                shift_q <= 37'h0;
                reading_q <= 1'b0;
            end
            if (!le && sck_rise && !reading_q) begin
                shift_q <= {shift_q[35:0], sd_s_q[1]};
                if (count_q != 6'h3F)
                    count_q <= count_q + 6'd1;
            end
            // status read: after address and read bit, drive strength bits
            if (!le && !le_fall && !reading_q && is_len(count_q, `LEN_STATUS)
                && shift_q[4:0] == `STATUS_ADDR) begin
                reading_q <= 1'b1;
                rd_idx_q <= 3'h0;
            end
            if (reading_q && sck_fall) begin
                serial_data_line_oe_n <= 1'b0;
                serial_data_line_out <= (rd_idx_q < 3'd6) ? signal_strength[rd_idx_q] : 1'b0;
                if (rd_idx_q != 3'h7)
                    rd_idx_q <= rd_idx_q + 3'd1;
            end
            if (le) begin
                serial_data_line_oe_n <= 1'b1;
            end
            if (le_rise && !reading_q) begin
                word_error <= 1'b0;
                if (is_len(count_q, `LEN_LONG)) begin
                    if (shift_q == `MAIN_TX && state_q != ST_TX) begin
                        main_control_word <= shift_q;
                        state_q <= ST_TX;
                    end else if (shift_q == `MAIN_RX || shift_q == `MAIN_RXCLK) begin
                        main_control_word <= shift_q;
                        state_q <= ST_RX;
                    end else if (shift_q == `MAIN_TX) begin
                        main_control_word <= shift_q;
                    end else if (shift_q[36:35] == 2'h0 && shift_q[34:33] == `TXF0_TAG
                                 || freq_seen_q == 2'h0 && shift_q[36:33] == 4'h0) begin
                        first_tx_frequency_word <= shift_q;
                        freq_seen_q <= 2'h1;
                    end else if (shift_q[36:33] == 4'h1) begin
                        second_tx_frequency_word <= shift_q;
                        freq_seen_q <= 2'h2;
                    end else if (shift_q[36:33] == 4'h2) begin
                        rx_frequency_word <= shift_q;
                        freq_seen_q <= 2'h3;
                    end else begin
                        word_error <= 1'b1;
                    end
                end else if (is_len(count_q, `LEN_CLKREC)) begin
                    bit_clock_recovery_word <= shift_q[26:0];
                end else if (is_len(count_q, `LEN_AUX)) begin
                    auxiliary_control_word <= shift_q[6:0];
                end else if (is_len(count_q, `LEN_SHORT)) begin
                    case (shift_q[5:0])
                    `CMD_STANDBY: begin
                        if (state_q != ST_STANDBY)
                            prev_q <= state_q;
                        state_q <= ST_STANDBY;
                    end
                    `CMD_WAKE: begin
                        // aux kept at 45h from transmit, so skip is harmless
                        if (prev_q == ST_TX && auxiliary_control_word == `AUX_TX)
                            state_q <= ST_TX;
                        else if (prev_q == ST_RX && auxiliary_control_word == `AUX_RX)
                            state_q <= ST_RX;
                        else
                            word_error <= 1'b1;
                    end
                    `CMD_RESET: begin
                        first_tx_frequency_word <= 37'h0;
                        second_tx_frequency_word <= 37'h0;
                        rx_frequency_word <= 37'h0;
                        bit_clock_recovery_word <= 27'h0;
                        auxiliary_control_word <= 7'h0;
                        main_control_word <= 37'h0;
                        freq_seen_q <= 2'h0;
                        prev_q <= ST_STANDBY;
                        state_q <= ST_STANDBY;
                    end
                    default: begin
                        word_error <= 1'b1;
                    end
                    endcase
                end else begin
                    word_error <= 1'b1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // status outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_active <= 1'b0;
            rx_active <= 1'b0;
            standby <= 1'b1;
            recovered_clock_en <= 1'b0;
        end else if (ce) begin
            tx_active <= (state_q == ST_TX);
            rx_active <= (state_q == ST_RX);
            standby <= (state_q == ST_STANDBY);
            recovered_clock_en <= (state_q == ST_RX)
                && (main_control_word == `MAIN_RXCLK);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    bit_clock_gen #(
        .DIV_W(16)
    ) u_bit_clock_gen (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(recovered_clock_en),
        .half_bit(bit_clock_recovery_word[15:0]),
        .rx_data(rx_data),
        .bit_clk(recovered_bit_clock)
    );
endmodule

// [bench/host_model.sv]
// host controller model driving the three-wire programming bus
`timescale 1ns/1ps
module host_model (
    // clock that frames are aligned to
    input logic clk,
    // three-wire bus
    input logic sdin,
    output logic le,
    output logic sclk,
    output logic sdat
);
    initial begin
        le = 1'b1;
        sclk = 1'b0;
        sdat = 1'b0;
    end
    // one word msb first, one pulse a bit, clock still outside frames
    task automatic send(input int n, input logic [36:0] v);
        @(posedge clk);
        #7 le = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdat = v[i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        #100 le = 1'b1;
        sdat = ~sdat;
        #300;
    endtask
    // status read: address and read select, then strength bits lsb first
    task automatic read(output logic [5:0] s);
        logic [4:0] a;
        a = 5'h0B;
        @(posedge clk);
        #7 le = 1'b0;
        for (int i = 0; i < 11; i++) begin
            if (i < 5) sdat = a[4 - i];
            #100 sclk = 1'b1;
            if (i >= 5) s[i - 5] = sdin;
            #100 sclk = 1'b0;
        end
        #100 le = 1'b1;
        #300;
    endtask
endmodule

// [bench/cfg_loader_assertions.sv]
// concurrent checks on the configuration loader ports
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module cfg_loader_assertions (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // bus
    input wire load_enable_line,
    input wire serial_data_line_oe_n,
    // status
    input wire tx_active,
    input wire rx_active,
    input wire standby,
    input wire recovered_clock_en,
    input wire recovered_bit_clock,
    input wire [6:0] auxiliary_control_word,
    input wire [36:0] main_control_word,
    input wire word_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_reset_state: assert property (disable iff (1'b0)
        !rst_n |=> standby && !tx_active && !rx_active && auxiliary_control_word == 7'h00)
        else $error("reset did not clear state");
    chk_mode_excl: assert property (
        !(standby && (tx_active || rx_active)) && !(tx_active && rx_active))
        else $error("modes overlap");
    chk_tx_aux: assert property ($rose(tx_active) |-> auxiliary_control_word == `AUX_TX)
        else $error("transmit without aux 45");
    chk_rx_aux: assert property ($rose(rx_active) |-> auxiliary_control_word == `AUX_RX)
        else $error("receive without aux 44");
    chk_words_hold: assert property (!load_enable_line [*6] |->
        $stable(auxiliary_control_word) && $stable(main_control_word))
        else $error("word changed during a frame");
    chk_err_nostore: assert property ($rose(word_error) |->
        $stable(auxiliary_control_word) && $stable(main_control_word))
        else $error("bad word was stored");
    chk_clk_off: assert property (!recovered_clock_en [*3] |-> !recovered_bit_clock)
        else $error("bit clock runs while disabled");
    chk_oe_idle: assert property (load_enable_line [*6] |-> serial_data_line_oe_n)
        else $error("data line driven outside frame");
    cover property ($rose(tx_active));
    cover property ($rose(recovered_clock_en));
    cover property ($rose(word_error));
    cover property ($fell(serial_data_line_oe_n));
endmodule
bind radio_transceiver_config_loader cfg_loader_assertions i_chk (.clk, .rst_n,
    .load_enable_line, .serial_data_line_oe_n, .tx_active, .rx_active, .standby,
    .recovered_clock_en, .recovered_bit_clock, .auxiliary_control_word,
    .main_control_word, .word_error);

// [bench/testbench.sv]
// self-checking bench of the configuration loader
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_data = 1'b0;
    logic rx_hold = 1'b0;
    logic [5:0] signal_strength = 6'h00;
    logic ss_hold = 1'b0;
    logic [10:0] rx_cnt = 11'h000;
    logic [5:0] rd;
    wire [36:0] f0_w, f1_w, f2_w, main_w;
    wire [26:0] rec_w;
    wire le, sclk, sdat, sd_out, sd_oe_n, bclk;
    wire tx_active, rx_active, standby, recovered_clock_en, word_error;
    wire [6:0] auxiliary_control_word;
    wire sd_wire = sd_oe_n ? sdat : sd_out;
    wire [11:0] snap = {tx_active, rx_active, standby, recovered_clock_en, word_error,
        auxiliary_control_word};
    int seed = 70;
    int n_fail = 0;
    int num_checks = 0;
    logic [11:0] exp_q[$];
    initial begin
        forever #12.5 clk = ~clk;
    end
    host_model i_host (.clk(clk), .sdin(sd_wire), .le(le), .sclk(sclk), .sdat(sdat));
    radio_transceiver_config_loader i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .load_enable_line(le), .serial_clock_line(sclk), .serial_data_line_in(sd_wire),
        .serial_data_line_out(sd_out), .serial_data_line_oe_n(sd_oe_n), .rx_data(rx_data),
        .signal_strength(signal_strength), .tx_active(tx_active), .rx_active(rx_active),
        .standby(standby), .recovered_clock_en(recovered_clock_en),
        .recovered_bit_clock(bclk), .first_tx_frequency_word(f0_w),
        .second_tx_frequency_word(f1_w), .rx_frequency_word(f2_w),
        .bit_clock_recovery_word(rec_w), .auxiliary_control_word(auxiliary_control_word),
        .main_control_word(main_w),
        .word_error(word_error));
    // radio data as manchester halves of a 25 kBps bit, strength random unless held
    always @(posedge clk) begin
        if (!ss_hold) signal_strength <= 6'($random(seed));
        rx_cnt <= (rx_cnt == 11'h63F) ? 11'h000 : rx_cnt + 11'h001;
        if (!rx_hold && rx_cnt == 11'h000) rx_data <= 1'($random(seed));
        if (!rx_hold && rx_cnt == 11'h320) rx_data <= ~rx_data;
    end
    task automatic cmp(input string what, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_word(input string what, input logic [36:0] e, input logic [36:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input int n, input logic [36:0] v, input logic [11:0] e);
        exp_q.push_back(e);
        i_host.send(n, v);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // result monitor, settled state after each latch
    always @(posedge le) begin
        if (rst_n && exp_q.size() > 0) begin
            repeat (8) @(posedge clk);
            cmp("mode and aux", exp_q.pop_front(), snap);
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp("reset state", 12'h200, snap);
        wr(37, 37'h019CD440E2, 12'h200);
        wr(37, 37'h03085464E6, 12'h200);
        wr(7, 37'h45, 12'h245);
        wr(37, 37'h09DB005260, 12'h845);
        cmp_word("first tx word", 37'h019CD440E2, f0_w);
        cmp_word("second tx word", 37'h03085464E6, f1_w);
        cmp_word("main word", 37'h09DB005260, main_w);
        wr(6, 37'h12, 12'h245);
        wr(6, 37'h13, 12'h845);
        wr(6, 37'h2E, 12'h200);
        cmp_word("first tx word", 37'h0, f0_w);
        cmp_word("main word", 37'h0, main_w);
        repeat (14000) @(posedge clk);
        wr(37, 37'h05C14DD4C8, 12'h200);
        wr(7, 37'h44, 12'h244);
        wr(37, 37'h0990000260, 12'h444);
        wr(7, 37'h45, 12'h445);
        wr(6, 37'h12, 12'h245);
        wr(6, 37'h13, 12'h2C5);
        wr(7, 37'h44, 12'h244);
        wr(6, 37'h13, 12'h444);
        ss_hold <= 1'b1;
        @(posedge clk);
        exp_q.push_back(12'h444);
        i_host.read(rd);
        cmp("signal strength", {6'h00, signal_strength}, {6'h00, rd});
        ss_hold <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            int n;
            n = 8 + ($random(seed) & 15);
            wr(n, 37'($random(seed)) | (37'h1 << (n - 1)), 12'h4C4);
        end
        rx_hold <= 1'b1;
        wr(37, 37'h05C14DD4C8, 12'h444);
        wr(27, 37'h7D40266, 12'h444);
        wr(7, 37'h44, 12'h444);
        wr(37, 37'h09B0000260, 12'h544);
        cmp_word("rx word", 37'h05C14DD4C8, f2_w);
        cmp_word("recovery word", 37'h7D40266, {10'h000, rec_w});
        cmp_word("main word", 37'h09B0000260, main_w);
        for (int i = 0; i < 2000 && bclk !== 1'b0; i++) @(posedge clk);
        cmp("bit clock low", 12'h000, {11'h000, bclk});
        for (int i = 0; i < 2000 && bclk !== 1'b1; i++) @(posedge clk);
        cmp("bit clock", 12'h001, {11'h000, bclk});
        wr(6, 37'h2E, 12'h200);
        cmp_word("recovery word", 37'h0, {10'h000, rec_w});
        end_sim();
    end
endmodule
